// File: uart_mls_pkg.sv
// constants for the modem control, line status and modem status block
package uart_mls_pkg;

  // register word addresses (one register per address)
  localparam logic [3:0] addr_modem_control = 4'h0;
  localparam logic [3:0] addr_line_state    = 4'h1;
  localparam logic [3:0] addr_modem_state   = 4'h2;
  localparam logic [3:0] addr_ext_control   = 4'h3;
  localparam logic [3:0] addr_ext_control2  = 4'h4;
  localparam logic [3:0] addr_divisor_low   = 4'h5;
  localparam logic [3:0] addr_divisor_high  = 4'h6;
  localparam logic [3:0] addr_irq_enable    = 4'h7;

  // modem control and ext control 2 lock field positions
  localparam int mc_dtr  = 0;
  localparam int mc_rts  = 1;
  localparam int mc_ring = 2;
  localparam int mc_gate = 3;
  localparam int mc_loop = 4;
  localparam int ext2_lock = 7;

  // interrupt enable field positions
  localparam int ie_line  = 2;
  localparam int ie_modem = 3;

  // reset values
  localparam logic [7:0] line_state_reset = 8'h60;
  localparam logic [7:0] zero_byte        = 8'h00;

  // bus read answer latency in cycles after the request
  localparam int read_wait_cycles = 1;

endpackage

// File: uart_scratch_if.sv
// interface between the main block and its scratch memory
`timescale 1ns/1ps
interface uart_scratch_if;
  logic       wr_en;
  logic       addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport owner (output wr_en, output addr, output wr_data, input rd_data);
  modport store (input wr_en, input addr, input wr_data, output rd_data);
endinterface

// File: uart_scratch_mem.sv
// two byte scratch store with registered read data
`timescale 1ns/1ps
module uart_scratch_mem
(
  input  wire logic     clk_sys,
  input  wire logic     sys_rst,
  uart_scratch_if.store mem
);

  logic [7:0] cells [0:1];
  logic [7:0] rd_q;

  always_ff @(posedge clk_sys)
  begin
    if (mem.wr_en)
      cells[mem.addr] <= mem.wr_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rd_q <= uart_mls_pkg::zero_byte;
    else
      rd_q <= cells[mem.addr];
  end

  assign mem.rd_data = rd_q;

endmodule

// File: uart_modem_line_status.sv
// modem control, line status and modem status logic with avalon slave
//
// Function
// - legacy: control bit 0 drives dtr low; loopback feeds dsr
// - legacy: control bit 1 drives rts low; loopback feeds cts
// - legacy loopback: control bit 2 feeds ring, else unused
// - legacy: bit 3 gates irq; loopback keeps irq on, bit feeds dcd
// - loopback bit shared by control bit 4 and ext control bit 4
// - extended: irq always enabled, loop only via ext control bit 4
// - extended: bit 0 feeds dsr and ring, bit 1 feeds cts and dcd
// - extended: bit 3 enables send deferral when queue enabled
// - lock set in legacy: divisor port writes reach scratch registers, reads return zero
// - line status error bits reset to 0 (0x60 read with tx idle), clear on rx reset or read
// - line status bits 4..1 raise line status irq when enabled
// - bit 0 set while received data waits, cleared when drained
// - overrun flag set on arrival while full, cleared on read
// - parity flag reported with its character at queue head
// - framing flag set when stop bit sampled zero
// - break flag set with the single zero character at head
// - bit 5 set when transmit holding empty, cleared by write
// - bit 6 set when transmit holding empty and shifter idle
// - bit 7 set on queued errors, zero without queues, follows rx_queue_has_error, not cleared by read
// - change bits 0..3 latch edges, raise event, clear on read
// - bits 4..7 return inverse of cts, dsr, ri, dcd
// - loopback disconnects modem inputs, change detect unchanged
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module uart_modem_line_status
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0] avs_byteenable,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       dcd_n,
  output logic            dtr_n,
  output logic            rts_n,
  input  wire logic       extended_mode,
  input  wire logic       queue_enable,
  input  wire logic       rx_soft_reset,
  input  wire logic       rx_char_done,
  input  wire logic       rx_parity_bad,
  input  wire logic       rx_frame_bad,
  input  wire logic       rx_break,
  input  wire logic       rx_holding_full,
  input  wire logic       rx_queue_full,
  input  wire logic       rx_queue_nonempty,
  input  wire logic       rx_head_parity,
  input  wire logic       rx_head_frame,
  input  wire logic       rx_head_break,
  input  wire logic       rx_queue_has_error,
  input  wire logic       tx_holding_empty,
  input  wire logic       tx_shifter_idle,
  input  wire logic       irq_core,
  output logic            irq_out,
  output logic            line_status_irq,
  output logic            modem_status_event,
  output logic            send_deferral,
  output logic            tx_data_write,
  output logic            rx_data_read
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] modem_control_reg;
  logic       loop_en;
  logic [7:0] ext_control_one;
  logic [7:0] ext_control_two;
  logic [7:0] irq_enable_reg;
  logic [4:0] line_state_reg;
  logic [3:0] modem_change;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] line_prev;
  logic       pending;
  logic       rd_phase;

  uart_scratch_if scr ();

  uart_scratch_mem u_scratch
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .mem     (scr.store)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  wire       wr_ok    = avs_write & avs_byteenable[0] & ~avs_waitrequest;
  wire       rd_ok    = avs_read & ~avs_waitrequest;
  wire [7:0] wd       = avs_writedata[7:0];
  wire       lock_on  = ext_control_two[uart_mls_pkg::ext2_lock];
  wire       scr_mode = lock_on & ~extended_mode;
  wire       div_hit  = hit(avs_address, uart_mls_pkg::addr_divisor_low) |
                        hit(avs_address, uart_mls_pkg::addr_divisor_high);
  // read side effects at the edge that captures the data, so that a
  // flag set at that same edge survives for the next read
  wire       rd_take  = avs_read & ~rd_phase;
  wire       rd_line  = rd_take & hit(avs_address,
                                    uart_mls_pkg::addr_line_state);
  wire       rd_modem = rd_take & hit(avs_address,
                                    uart_mls_pkg::addr_modem_state);

  // ---------------------------------------------------------------
  // modem line routing
  // ---------------------------------------------------------------
  // order in vectors: 0 cts, 1 dsr, 2 ri, 3 dcd, active high (inverse)
  wire dtr_b  = modem_control_reg[uart_mls_pkg::mc_dtr];
  wire rts_b  = modem_control_reg[uart_mls_pkg::mc_rts];
  wire ring_b = modem_control_reg[uart_mls_pkg::mc_ring];
  wire gate_b = modem_control_reg[uart_mls_pkg::mc_gate];
  wire [3:0] loop_lines = extended_mode ?
                          {rts_b, dtr_b, dtr_b, rts_b} :
                          {gate_b, ring_b, dtr_b, rts_b};
  wire [3:0] pin_lines  = ~sync_b;
  wire [3:0] cur_lines  = loop_en ? loop_lines : pin_lines;
  wire [3:0] delta      = {cur_lines[3] ^ line_prev[3],
                           ~cur_lines[2] & line_prev[2],
                           cur_lines[1:0] ^ line_prev[1:0]};

  wire irq_en   = extended_mode | loop_en | gate_b;
  wire lsr_err  = |line_state_reg[4:1];
  wire err_head = queue_enable ? 1'b0 : 1'b1;
  wire data_av  = queue_enable ? rx_queue_nonempty : rx_holding_full;
  wire over     = rx_char_done & (queue_enable ? rx_queue_full
                                               : rx_holding_full);
  wire q_err    = queue_enable & rx_queue_has_error;

  wire [7:0] lsr_view = {q_err,
                         tx_holding_empty & tx_shifter_idle,
                         tx_holding_empty,
                         line_state_reg[4:1], data_av};
  wire [7:0] msr_view = {cur_lines, modem_change};
  wire [7:0] mcr_view = extended_mode ?
                        {4'h0, modem_control_reg[3], 1'b0,
                         modem_control_reg[1:0]} :
                        {3'h0, loop_en, modem_control_reg};

  logic [7:0] rd_mux;
  always_comb
  begin
    case (avs_address)
      uart_mls_pkg::addr_modem_control: rd_mux = mcr_view;
      uart_mls_pkg::addr_line_state:    rd_mux = lsr_view;
      uart_mls_pkg::addr_modem_state:   rd_mux = msr_view;
      uart_mls_pkg::addr_ext_control:   rd_mux = {ext_control_one[7:5],
                                                  loop_en,
                                                  ext_control_one[3:0]};
      uart_mls_pkg::addr_ext_control2:  rd_mux = ext_control_two;
      uart_mls_pkg::addr_irq_enable:    rd_mux = irq_enable_reg;
      default:                          rd_mux = uart_mls_pkg::zero_byte;
    endcase
  end

  assign scr.wr_en   = wr_ok & div_hit & scr_mode;
  assign scr.addr    = hit(avs_address, uart_mls_pkg::addr_divisor_high);
  assign scr.wr_data = wd;

  // ---------------------------------------------------------------
  // avalon handshake: one wait cycle on reads for registered data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rd_phase <= 1'b0;
    else
      rd_phase <= avs_read & ~rd_phase;
  end

  always_comb
  begin
    avs_waitrequest = avs_read & ~rd_phase;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~rd_phase)
      avs_readdata <= {24'h00_0000, rd_mux};
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      modem_control_reg <= 4'h0;
      loop_en           <= 1'b0;
      ext_control_one   <= uart_mls_pkg::zero_byte;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        uart_mls_pkg::addr_modem_control:
        begin
          modem_control_reg <= extended_mode ? {wd[3], 1'b0, wd[1:0]}
                                             : wd[3:0];
          if (!extended_mode)
            loop_en <= wd[uart_mls_pkg::mc_loop];
        end
        uart_mls_pkg::addr_ext_control:
        begin
          ext_control_one <= {wd[7:5], 1'b0, wd[3:0]};
          loop_en         <= wd[uart_mls_pkg::mc_loop];
        end
        default:                         loop_en         <= loop_en;
      endcase
    end
  end

  // lock and interrupt enable bytes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ext_control_two <= uart_mls_pkg::zero_byte;
      irq_enable_reg  <= uart_mls_pkg::zero_byte;
    end
    else if (wr_ok & hit(avs_address, uart_mls_pkg::addr_ext_control2))
      ext_control_two <= wd;
    else if (wr_ok & hit(avs_address, uart_mls_pkg::addr_irq_enable))
      irq_enable_reg  <= wd;
  end

  // ---------------------------------------------------------------
  // line status flags, set beats read clear
  // ---------------------------------------------------------------
  wire [4:1] err_set = {rx_char_done & rx_break & err_head |
                          rx_head_break & queue_enable,
                        rx_char_done & rx_frame_bad & err_head |
                          rx_head_frame & queue_enable,
                        rx_char_done & rx_parity_bad & err_head |
                          rx_head_parity & queue_enable,
                        over};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | rx_soft_reset)
      line_state_reg <= uart_mls_pkg::line_state_reset[4:0];
    else
      line_state_reg <= {err_set, 1'b0} |
                        (rd_line ? 5'h00 : line_state_reg);
  end

  // ---------------------------------------------------------------
  // modem status: pin sync and change latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    sync_a <= {dcd_n, ri_n, dsr_n, cts_n};
    sync_b <= sync_a;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      modem_change <= 4'h0;
      line_prev    <= 4'h0;
    end
    else
    begin
      line_prev    <= cur_lines;
      modem_change <= delta | (rd_modem ? 4'h0 : modem_change);
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  wire port_lo  = div_hit & ~scr_mode &
                  hit(avs_address, uart_mls_pkg::addr_divisor_low);
  wire tx_take  = wr_ok & port_lo;
  wire rx_take  = rd_ok & port_lo;
  wire ls_irq   = lsr_err & irq_enable_reg[uart_mls_pkg::ie_line];
  wire ms_event = (|modem_change) &
                  irq_enable_reg[uart_mls_pkg::ie_modem];
  wire defer_on = extended_mode & queue_enable &
                  modem_control_reg[uart_mls_pkg::mc_gate];

  // modem control pins, inactive after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
    end
    else
    begin
      dtr_n <= ~dtr_b;
      rts_n <= ~rts_b;
    end
  end

  // interrupt request and event levels
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_out            <= 1'b0;
      line_status_irq    <= 1'b0;
      modem_status_event <= 1'b0;
    end
    else
    begin
      irq_out            <= irq_core & irq_en;
      line_status_irq    <= ls_irq;
      modem_status_event <= ms_event;
    end
  end

  // deferral level and data port strobes, one cycle each
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      send_deferral <= 1'b0;
      tx_data_write <= 1'b0;
      rx_data_read  <= 1'b0;
    end
    else
    begin
      send_deferral <= defer_on;
      tx_data_write <= tx_take;
      rx_data_read  <= rx_take;
    end
  end

endmodule

// File: uart_mls_chk.sv
// assertions on the ports of the modem and line status block
`timescale 1ns/1ps
module uart_mls_chk
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        extended_mode,
  input wire logic        queue_enable,
  input wire logic        irq_core,
  input wire logic        irq_out,
  input wire logic        line_status_irq,
  input wire logic        send_deferral,
  input wire logic        tx_data_write
);
  // ----------------------------
  // register shadows and checks
  // ----------------------------
  logic [3:0] mc;
  logic       loop;
  logic       lock;
  logic       ie_ls;
  logic [1:0] since;
  wire        w_ok = avs_write && avs_byteenable[0];
  wire        w_mc = w_ok && avs_address == uart_mls_pkg::addr_modem_control;
  wire        w_x1 = w_ok && avs_address == uart_mls_pkg::addr_ext_control;
  wire        w_x2 = w_ok && avs_address == uart_mls_pkg::addr_ext_control2;
  wire        w_ie = w_ok && avs_address == uart_mls_pkg::addr_irq_enable;
  wire        w_dl = w_ok && avs_address == uart_mls_pkg::addr_divisor_low;
  wire        w_lp = w_x1 || (w_mc && !extended_mode);
  wire        w_any = w_mc || w_x1 || w_x2 || w_ie;
  wire        ovl = lock && !extended_mode;
  always_ff @(posedge clk_sys)
  begin
    mc    <= sys_rst ? 4'h0 : (w_mc ? avs_writedata[3:0] : mc);
    loop  <= sys_rst ? 1'b0 : (w_lp ? avs_writedata[4] : loop);
    lock  <= sys_rst ? 1'b0 : (w_x2 ? avs_writedata[7] : lock);
    ie_ls <= sys_rst ? 1'b0 : (w_ie ? avs_writedata[2] : ie_ls);
    since <= (sys_rst || w_any) ? 2'h0 : since + {1'b0, since != 2'h3};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rd_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_wr_go; avs_write |-> !avs_waitrequest; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write wait");
  property p_rst; $fell(sys_rst) |-> dtr_n && rts_n && !irq_out
    && !send_deferral && !line_status_irq; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_pins;
    since >= 2 |-> dtr_n == !mc[0] && rts_n == !mc[1]; endproperty
  a_pins: assert property (p_pins) else $error("dtr rts");
  property p_gate; since >= 2 && !extended_mode && !$past(extended_mode)
    |-> irq_out == ($past(irq_core) && (mc[3] || loop)); endproperty
  a_gate: assert property (p_gate) else $error("irq gate");
  property p_ext; since >= 2 && extended_mode && $past(extended_mode)
    |-> irq_out == $past(irq_core); endproperty
  a_ext: assert property (p_ext) else $error("irq ext");
  property p_dfr; since >= 2 |-> send_deferral ==
    ($past(extended_mode) && $past(queue_enable) && mc[3]); endproperty
  a_dfr: assert property (p_dfr) else $error("deferral");
  property p_lsi; since >= 2 && !ie_ls |-> !line_status_irq; endproperty
  a_lsi: assert property (p_lsi) else $error("line irq");
  property p_txp; w_dl |=> tx_data_write == !$past(ovl); endproperty
  a_txp: assert property (p_txp) else $error("data port");
endmodule

bind uart_modem_line_status uart_mls_chk i_chk
(
  .clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .dtr_n, .rts_n, .extended_mode,
  .queue_enable, .irq_core, .irq_out, .line_status_irq, .send_deferral,
  .tx_data_write
);

// File: modem_model.sv
// data set model driving the modem status lines
`timescale 1ns/1ps
module modem_model
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] lines_req,
  input  wire logic       dtr_n,
  input  wire logic       rts_n,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            dcd_n
);
  // ----------------------------
  // line drivers, always a level
  // ----------------------------
  always_ff @(posedge clk_sys)
  begin
    {dcd_n, ri_n, dsr_n, cts_n} <= lines_req;
  end
endmodule

// File: test_uart_modem_line_status.sv
// self-checking bench for the modem and line status block
`timescale 1ns/1ps
module test_uart_modem_line_status;
  // ----------------
  // signals and dut
  // ----------------
  logic        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, lines_req;
  logic [31:0] avs_writedata, avs_readdata;
  logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, extended_mode;
  logic        queue_enable, rx_soft_reset, rx_char_done, rx_parity_bad;
  logic        rx_frame_bad, rx_break, rx_holding_full, rx_queue_full;
  logic        rx_queue_nonempty, rx_head_parity, rx_head_frame;
  logic        rx_head_break, rx_queue_has_error, tx_holding_empty;
  logic        tx_shifter_idle, irq_core, irq_out, line_status_irq;
  logic        modem_status_event, send_deferral, tx_data_write;
  logic        rx_data_read;
  logic [7:0]  q;
  int          mismatches, checks_done;
  uart_modem_line_status i_dut (.*);
  modem_model i_modem (.clk_sys, .lines_req, .dtr_n, .rts_n, .cts_n, .dsr_n,
                       .ri_n, .dcd_n);
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int   n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20)
      mismatches++;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, e, string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q & m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset;
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'h60, "lsr");
    rd(uart_mls_pkg::addr_modem_state, 8'hf0, 8'h00, "msr");
    rd(4'h8, 8'hff, 8'h00, "unmapped");
    rd(uart_mls_pkg::addr_modem_control, 8'h10, 8'h00, "loop");
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h03);
    idle(3);
    chk("pins", 8'h00, {6'h0, dtr_n, rts_n});
    $display("test reset done");
  endtask
  task automatic t_pins;
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h00);
    bus(1'b1, uart_mls_pkg::addr_irq_enable, 8'h08);
    lines_req <= 4'h0;
    idle(6);
    chk("event", 8'h01, {7'h0, modem_status_event});
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'hfb, "msr");
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'hf0, "msr");
    chk("event", 8'h00, {7'h0, modem_status_event});
    lines_req <= 4'hf;
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'h0f, "msr");
    $display("test pins done");
  endtask
  task automatic t_loop;
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h1f);
    lines_req <= 4'h0;
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'hfb, "msr");
    rd(uart_mls_pkg::addr_ext_control, 8'h10, 8'h10, "x1");
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h10);
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'h0f, "msr");
    bus(1'b1, uart_mls_pkg::addr_ext_control, 8'h00);
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hf0, 8'hf0, "msr");
    rd(uart_mls_pkg::addr_modem_control, 8'h10, 8'h00, "mc");
    lines_req <= 4'hf;
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hf0, 8'h00, "msr");
    $display("test loop done");
  endtask
  task automatic t_ext;
    extended_mode <= 1'b1;
    queue_enable  <= 1'b1;
    irq_core      <= 1'b1;
    bus(1'b1, uart_mls_pkg::addr_ext_control, 8'h10);
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h01);
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'h62, "msr");
    chk("irq", 8'h01, {7'h0, irq_out});
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h02);
    idle(5);
    rd(uart_mls_pkg::addr_modem_state, 8'hff, 8'h9f, "msr");
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h08);
    idle(3);
    chk("defer", 8'h01, {7'h0, send_deferral});
    queue_enable <= 1'b0;
    idle(3);
    chk("defer", 8'h00, {7'h0, send_deferral});
    bus(1'b1, uart_mls_pkg::addr_ext_control, 8'h00);
    extended_mode <= 1'b0;
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h00);
    idle(3);
    chk("irq", 8'h00, {7'h0, irq_out});
    bus(1'b1, uart_mls_pkg::addr_modem_control, 8'h08);
    idle(3);
    chk("irq", 8'h01, {7'h0, irq_out});
    irq_core <= 1'b0;
    $display("test extended done");
  endtask
  task automatic t_lsr;
    bus(1'b1, uart_mls_pkg::addr_irq_enable, 8'h04);
    {rx_char_done, rx_parity_bad, rx_frame_bad, rx_break} <= 4'hf;
    rx_queue_has_error <= 1'b1;
    idle(1);
    {rx_char_done, rx_parity_bad, rx_frame_bad, rx_break} <= 4'h0;
    rx_holding_full <= 1'b1;
    idle(3);
    chk("lsirq", 8'h01, {7'h0, line_status_irq});
    bus(1'b1, uart_mls_pkg::addr_line_state, 8'hff);
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'h7d, "lsr");
    idle(2);
    chk("lsirq", 8'h00, {7'h0, line_status_irq});
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'h61, "lsr");
    rx_char_done <= 1'b1;
    idle(1);
    rx_char_done <= 1'b0;
    idle(2);
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'h63, "lsr");
    {rx_holding_full, tx_holding_empty, rx_char_done, rx_parity_bad} <= 4'h3;
    idle(1);
    {rx_char_done, rx_parity_bad, rx_soft_reset} <= 3'h1;
    idle(1);
    rx_soft_reset <= 1'b0;
    idle(2);
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'h00, "lsr");
    {queue_enable, rx_queue_nonempty, rx_head_parity} <= 3'h7;
    {tx_holding_empty, tx_shifter_idle} <= 2'h2;
    idle(3);
    rd(uart_mls_pkg::addr_line_state, 8'hff, 8'ha5, "lsr");
    {queue_enable, rx_queue_nonempty, rx_head_parity} <= 3'h0;
    $display("test line status done");
  endtask
  task automatic t_port;
    bus(1'b1, uart_mls_pkg::addr_divisor_low, 8'h55);
    idle(1);
    chk("txwr", 8'h01, {7'h0, tx_data_write});
    rd(uart_mls_pkg::addr_divisor_low, 8'hff, 8'h00, "data");
    idle(1);
    chk("rxrd", 8'h01, {7'h0, rx_data_read});
    bus(1'b1, uart_mls_pkg::addr_ext_control2, 8'h80);
    bus(1'b1, uart_mls_pkg::addr_divisor_low, 8'haa);
    idle(1);
    chk("txwr", 8'h00, {7'h0, tx_data_write});
    rd(uart_mls_pkg::addr_divisor_low, 8'hff, 8'h00, "scratch");
    idle(1);
    chk("rxrd", 8'h00, {7'h0, rx_data_read});
    $display("test overlay done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 38'h0};
    {avs_byteenable, lines_req, extended_mode, queue_enable} = 10'h0fc;
    {rx_soft_reset, rx_char_done, rx_parity_bad, rx_frame_bad} = 4'h0;
    {rx_break, rx_holding_full, rx_queue_full, rx_queue_nonempty} = 4'h0;
    {rx_head_parity, rx_head_frame, rx_head_break, irq_core} = 4'h0;
    {rx_queue_has_error, tx_holding_empty, tx_shifter_idle} = 3'h3;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset;
    t_pins;
    t_loop;
    t_ext;
    t_lsr;
    t_port;
    results;
  end
  initial
  begin
    #200000;
    mismatches++;
    results;
  end
endmodule
